//--- design/exec_unit.sv
// execution unit for compare-skip, decimal adjust and the two returns
`timescale 1ns/1ps
`default_nettype none
`include "exec_unit_map.svh"
module exec_unit (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp
);
	exec_unit_pkg::exec_state_type state;
	exec_unit_pkg::op_kind_type    kind;
	logic [15:0] instr;
	logic [7:0]  working_register;
	logic [15:0] top_of_stack;
	logic [15:0] pc;
	logic [7:0]  pc_high_latch;
	logic        digit_carry_flag;
	logic        carry_flag;
	logic        global_interrupt_disable;
	logic        skip_done;
	logic        unknown_op;
	logic [7:0]  mem [0:`MEM_DEPTH-1];
	logic        ph_valid;
	logic        ph_write;
	logic [31:0] ph_addr;
	logic        go;
	logic [7:0]  operand;
	logic [7:0]  bcd_value;
	logic        bcd_carry;
	logic        mem_we;
	logic [7:0]  mem_wdata;
	logic        settling;

	// decode one instruction word into its kind
	function automatic exec_unit_pkg::op_kind_type decode(
		input logic [15:0] word
	);
		exec_unit_pkg::op_kind_type k;
		k = exec_unit_pkg::op_none_type_v;
		if (word[15:8] == `OP_CPFS_HI) begin
			k = exec_unit_pkg::op_cmp;
		end else if (word[15:9] == `OP_DAW_HI) begin
			k = exec_unit_pkg::op_bcd;
		end else if (word == `OP_RETURN_FROM_INTERRUPT) begin
			k = exec_unit_pkg::op_rfi;
		end else if (word[15:8] == `OP_RETURN_WITH_LITERAL_HI) begin
			k = exec_unit_pkg::op_rlw;
		end
		return k;
	endfunction : decode

	// register read mux, shared by address-phase loads and stall reloads
	function automatic logic [31:0] read_word(
		input logic [31:0] addr
	);
		logic [31:0] w;
		w = 32'h0000_0000;
		if (addr[31:10] == 22'h000001) begin
			w = {24'h000000, mem[addr[9:2]]};
		end else begin
			case (addr)
				`ADDR_CTRL:   w = {30'h0, global_interrupt_disable,
				                   digit_carry_flag};
				`ADDR_INSTR:  w = {16'h0000, instr};
				`ADDR_WORKING_REGISTER:   w = {24'h000000, working_register};
				`ADDR_TOS:    w = {16'h0000, top_of_stack};
				`ADDR_STATUS: w = {28'h0, carry_flag, unknown_op,
				                   skip_done, 1'b0};
				`ADDR_PC:     w = {8'h00, pc_high_latch, pc};
				default:      w = 32'h0000_0000;
			endcase
		end
		return w;
	endfunction : read_word

	// stall while executing and for one settle cycle after it
	assign hreadyout = (state == exec_unit_pkg::st_idle && !settling)
	                   || !ph_valid;
	assign hresp     = 1'b0;
	assign operand   = mem[instr[7:0]];

	// address phase capture; transfers wait while an instruction runs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_valid <= 1'b0;
			ph_write <= 1'b0;
			ph_addr  <= 32'h0000_0000;
		end else if (hready) begin
			ph_valid <= hsel && htrans[1];
			ph_write <= hwrite;
			ph_addr  <= haddr;
		end
	end

	// writing the instruction register starts execution
	assign go = ph_valid && ph_write && hreadyout
	            && (ph_addr == `ADDR_INSTR);

	bcd_adjust u_bcd (
		.value_in    (working_register),
		.digit_carry (digit_carry_flag),
		.carry_in    (carry_flag),
		.value_out   (bcd_value),
		.carry_out   (bcd_carry)
	);

	// sequencer: execute cycle, then an optional forced no-op
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= exec_unit_pkg::st_idle;
			kind  <= exec_unit_pkg::op_none_type_v;
			instr <= 16'h0000;
		end else begin
			case (state)
				exec_unit_pkg::st_idle: begin
					if (go) begin
						instr <= hwdata[15:0];
						kind  <= decode(hwdata[15:0]);
						state <= exec_unit_pkg::st_exec;
					end
				end
				exec_unit_pkg::st_exec: begin
					case (kind)
						exec_unit_pkg::op_cmp:
							state <= (operand < working_register)
							       ? exec_unit_pkg::st_nop
							       : exec_unit_pkg::st_idle;
						exec_unit_pkg::op_rfi,
						exec_unit_pkg::op_rlw:
							state <= exec_unit_pkg::st_nop;
						default:
							state <= exec_unit_pkg::st_idle;
					endcase
				end
				exec_unit_pkg::st_nop: begin
					state <= exec_unit_pkg::st_idle;
				end
				default: begin
					state <= exec_unit_pkg::st_idle;
				end
			endcase
		end
	end

	// memory write strobe: decimal adjust in the execute cycle, bus writes to memory while idle
	always_comb begin
		mem_we    = 1'b0;
		mem_wdata = bcd_value;
		if (state == exec_unit_pkg::st_exec
		    && kind == exec_unit_pkg::op_bcd) begin
			mem_we = 1'b1;
		end else if (state == exec_unit_pkg::st_idle && ph_valid
		             && ph_write && ph_addr[31:10] == 22'h000001) begin
			mem_we    = 1'b1;
			mem_wdata = hwdata[7:0];
		end
	end

	// data memory; no reset, software initialises it
	always_ff @(posedge hclk) begin
		if (mem_we) begin
			if (state == exec_unit_pkg::st_exec) begin
				mem[instr[7:0]] <= mem_wdata;
			end else begin
				mem[ph_addr[9:2]] <= mem_wdata;
			end
		end
	end

	// working register and flags
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			working_register <= 8'h00;
			carry_flag       <= 1'b0;
			digit_carry_flag <= 1'b0;
		end else if (state == exec_unit_pkg::st_exec) begin
			if (kind == exec_unit_pkg::op_bcd) begin
				carry_flag <= bcd_carry;
				if (!instr[8]) begin
					working_register <= bcd_value;
				end
			end else if (kind == exec_unit_pkg::op_rlw) begin
				working_register <= instr[7:0];
			end
		end else if (state == exec_unit_pkg::st_idle && ph_valid
		             && ph_write) begin
			if (ph_addr == `ADDR_WORKING_REGISTER) begin
				working_register <= hwdata[7:0];
			end
			if (ph_addr == `ADDR_CTRL) begin
				digit_carry_flag <= hwdata[`CTRL_DC_BIT];
			end
		end
	end

	// program counter, latch, stack top, interrupt disable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc                       <= `RESET_PC;
			pc_high_latch            <= `RESET_PC_HIGH_LATCH;
			top_of_stack             <= 16'h0000;
			global_interrupt_disable <= 1'b0;
		end else if (state == exec_unit_pkg::st_exec) begin
			case (kind)
				exec_unit_pkg::op_rfi: begin
					pc                       <= top_of_stack;
					global_interrupt_disable <= 1'b0;
				end
				exec_unit_pkg::op_rlw: begin
					pc <= top_of_stack;
				end
				exec_unit_pkg::op_cmp: begin
					pc <= (operand < working_register) ? pc + 16'h0002
					                                   : pc + 16'h0001;
				end
				default: begin
					pc <= pc + 16'h0001;
				end
			endcase
		end else if (state == exec_unit_pkg::st_idle && ph_valid
		             && ph_write) begin
			if (ph_addr == `ADDR_TOS) begin
				top_of_stack <= hwdata[15:0];
			end
			if (ph_addr == `ADDR_PC) begin
				pc            <= hwdata[15:0];
				pc_high_latch <= hwdata[23:16];
			end
			if (ph_addr == `ADDR_CTRL) begin
				global_interrupt_disable <= hwdata[`CTRL_GID_BIT];
			end
		end
	end

	// record of the last instruction outcome, rewritten each execute cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			skip_done  <= 1'b0;
			unknown_op <= 1'b0;
		end else if (state == exec_unit_pkg::st_exec) begin
			skip_done  <= (kind == exec_unit_pkg::op_cmp)
			              && (operand < working_register);
			unknown_op <= (kind == exec_unit_pkg::op_none_type_v);
		end
	end

	// settle flag: the results of the last execute cycle land on the
	// same edge that ends it, so a stalled read reloads one cycle later
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			settling <= 1'b0;
		end else begin
			settling <= (state != exec_unit_pkg::st_idle);
		end
	end

	// read data; unmapped addresses read zero
	// a read taken while an instruction runs would hold stale values,
	// so it is fetched again each stalled cycle from the held address
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			hrdata <= read_word(haddr);
		end else if (ph_valid && !ph_write && !hreadyout) begin
			hrdata <= read_word(ph_addr);
		end
	end
endmodule : exec_unit
`default_nettype wire

//--- design/exec_unit_map.svh
// constants for the compare, decimal adjust and return execution unit
`ifndef EXEC_UNIT_MAP_SVH
`define EXEC_UNIT_MAP_SVH
`define ADDR_CTRL          32'h0000_0000
`define ADDR_INSTR         32'h0000_0004
`define ADDR_WORKING_REGISTER          32'h0000_0008
`define ADDR_TOS           32'h0000_000C
`define ADDR_STATUS        32'h0000_0010
`define ADDR_PC            32'h0000_0014
`define ADDR_MEM_BASE      32'h0000_0400
`define CTRL_DC_BIT        0
`define CTRL_GID_BIT       1
`define STAT_BUSY_BIT      0
`define STAT_SKIP_BIT      1
`define STAT_UNK_BIT       2
`define OP_CPFS_HI         8'h30
`define OP_DAW_HI          7'h17
`define OP_RETURN_FROM_INTERRUPT          16'h0005
`define OP_RETURN_WITH_LITERAL_HI        8'hB6
`define BCD_LIMIT          4'h9
`define BCD_ADJ            4'h6
`define RESET_PC           16'h0000
`define RESET_PC_HIGH_LATCH       8'h00
`define MEM_DEPTH          256
`endif

//--- design/exec_unit_pkg.sv
// types shared by the execution unit
package exec_unit_pkg;
	typedef enum logic [2:0] {
		op_none_type_v,
		op_cmp,
		op_bcd,
		op_rfi,
		op_rlw
	} op_kind_type;
	typedef enum logic [1:0] {
		st_idle,
		st_exec,
		st_nop
	} exec_state_type;
endpackage : exec_unit_pkg

//--- design/bcd_adjust.sv
// combinational decimal adjust of the working register
`timescale 1ns/1ps
`default_nettype none
`include "exec_unit_map.svh"
module bcd_adjust (
	input  wire logic [7:0] value_in,
	input  wire logic       digit_carry,
	input  wire logic       carry_in,
	output logic      [7:0] value_out,
	output logic            carry_out
);
	logic [4:0] low_sum;
	logic [4:0] high_sum;
	logic       low_fix;
	logic       high_fix;
	// low nibble then high nibble, each corrected by six
	always_comb begin
		low_fix  = (value_in[3:0] > `BCD_LIMIT) || digit_carry;
		low_sum  = low_fix ? ({1'b0, value_in[3:0]} + {1'b0, `BCD_ADJ})
		                   : {1'b0, value_in[3:0]};
		high_sum = {1'b0, value_in[7:4]} + {4'h0, low_sum[4]};
		high_fix = (high_sum > 5'h09) || carry_in;
		if (high_fix) begin
			high_sum = high_sum + 5'h06;
		end
		value_out = {high_sum[3:0], low_sum[3:0]};
		carry_out = high_fix | high_sum[4];
	end
endmodule : bcd_adjust
`default_nettype wire

//--- tb/exec_unit_assertions.sv
// bus-side checks for the execution unit
`timescale 1ns/1ps
`default_nettype none
`include "exec_unit_map.svh"
module exec_unit_checker (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp
);
	logic        ph;
	logic        go;
	logic [15:0] op;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// instruction slot write sitting in its data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			ph <= 1'b0;
		else if (hready)
			ph <= hsel && htrans[1] && hwrite && haddr == `ADDR_INSTR;
	end
	assign go = ph && hready;
	assign op = hwdata[15:0];
	cmp_done_a: assert property (
		go && op[15:12] == 4'h3 |-> ##[1:3] hreadyout) else $error("cmp late");
	stall_limit_a: assert property (
		!hreadyout |-> ##[1:3] hreadyout) else $error("stall too long");
	daw_one_a: assert property (
		go && op[15:9] == `OP_DAW_HI |-> ##[1:2] hreadyout) else $error("daw late");
	rfi_done_a: assert property (
		go && op == `OP_RETURN_FROM_INTERRUPT |-> ##[1:3] hreadyout) else $error("rfi late");
	rlw_done_a: assert property (
		go && op[15:8] == `OP_RETURN_WITH_LITERAL_HI |-> ##[1:3] hreadyout) else $error("rlw late");
	idle_ready_a: assert property (
		!$past(go) && !$past(go, 2) && !$past(go, 3) |-> hreadyout)
		else $error("stall unasked");
	resp_okay_a: assert property (
		hresp == 1'b0) else $error("response not okay");
	reset_ready_a: assert property (
		$rose(hresetn) |-> hreadyout) else $error("not ready after reset");
	cover property (go && op[15:12] == 4'h3);
	cover property (go && op[15:9] == `OP_DAW_HI);
	cover property (go && op == `OP_RETURN_FROM_INTERRUPT);
endmodule : exec_unit_checker
bind exec_unit exec_unit_checker exec_unit_checker_inst (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp));
`default_nettype wire

//--- tb/prog_store.sv
// program store handing instruction words to the bench
`timescale 1ns/1ps
`default_nettype none
`include "exec_unit_map.svh"
module prog_store (
	input  wire logic [1:0]  kind,
	input  wire logic        dest,
	input  wire logic [7:0]  arg,
	output logic      [15:0] word
);
	// one word per kind, operand in the low byte except the fixed return from interrupt word
	always_comb begin
		case (kind)
			2'h0: word = {`OP_CPFS_HI, arg};
			2'h1: word = {`OP_DAW_HI, dest, arg};
			2'h2: word = `OP_RETURN_FROM_INTERRUPT;
			default: word = {`OP_RETURN_WITH_LITERAL_HI, arg};
		endcase
	end
endmodule : prog_store
`default_nettype wire

//--- tb/tb_compare_bcd_return_exec.sv
// self-checking bench for the execution unit
`timescale 1ns/1ps
`default_nettype none
`include "exec_unit_map.svh"
module tb_compare_bcd_return_exec;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        rd_ph;
	logic [1:0]  pk;
	logic        ps;
	logic [7:0]  pa;
	logic [15:0] pw;
	logic [31:0] exp_q[$];
	string       nm_q[$];
	int          err_count;
	int          tests_run;
	exec_unit exec_unit_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp));
	prog_store prog_store_inst (.kind(pk), .dest(ps), .arg(pa), .word(pw));
	always #2.5 hclk = ~hclk;
	task check(input string nm, input logic [31:0] seen, want);
		tests_run++;
		if (seen !== want) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, want, seen);
		end
	endtask : check
	task print_verdict;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict
	// bounded wait; a hung slave ends the run
	task wait_rdy;
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 40) begin
				err_count++;
				print_verdict;
			end
			@(posedge hclk);
		end
	endtask : wait_rdy
	// single transfer; a read notes its expected word first
	task ahb(input logic w, input logic [31:0] a, d, input string nm);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		if (!w) begin
			exp_q.push_back(d);
			nm_q.push_back(nm);
		end
		wait_rdy;
	endtask : ahb
	// fetch from the store, then hand the word to the unit
	task run(input logic [1:0] k, input logic s, input logic [7:0] a);
		pk = k;
		ps = s;
		pa = a;
		@(posedge hclk);
		ahb(1'b1, `ADDR_INSTR, {16'h0, pw}, "");
	endtask : run
	function logic [31:0] ma(input logic [7:0] f);
		return `ADDR_MEM_BASE + {22'h0, f, 2'h0};
	endfunction : ma
	function logic [7:0] bcd(input int x);
		return 8'((x / 10) * 16 + x % 10);
	endfunction : bcd
	task decimal_adjust_accumulator(input logic [7:0] v, input logic dc, s, input logic [7:0] f, r);
		ahb(1'b1, ma(f), {24'h0, ~r}, "");
		ahb(1'b1, `ADDR_WORKING_REGISTER, {24'h0, v}, "");
		ahb(1'b1, `ADDR_CTRL, {31'h0, dc}, "");
		run(2'h1, s, f);
		ahb(1'b0, ma(f), {24'h0, r}, "mem");
		ahb(1'b0, `ADDR_WORKING_REGISTER, {24'h0, s ? v : r}, "working_register");
	endtask : decimal_adjust_accumulator
	// takes the oldest note whenever a read data phase completes
	always @(posedge hclk) begin
		if (rd_ph && hreadyout === 1'b1)
			check(nm_q.pop_front(), hrdata, exp_q.pop_front());
		if (hreadyout === 1'b1)
			rd_ph <= hsel && htrans[1] && !hwrite;
	end
	initial begin
		logic [7:0]  m, w, f, k, pl, r, bn;
		logic [15:0] pc, t;
		logic        c0, dc;
		int          a, b;
		{hclk, hresetn, hsel, hwrite, rd_ph, ps} = 6'h00;
		{haddr, hwdata, htrans, pk, pa} = 76'h0;
		err_count = 0;
		tests_run = 0;
		void'($urandom(68));
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		// compare: working value just below, equal, above, then random
		for (int i = 0; i < 12; i++) begin
			m = 8'($urandom);
			w = (i < 4) ? m + 8'(i) - 8'h01 : 8'($urandom);
			f = 8'($urandom);
			{pl, pc} = 24'($urandom);
			c0 = 1'($urandom);
			ahb(1'b1, ma(f), {24'h0, m}, "");
			ahb(1'b1, `ADDR_WORKING_REGISTER, {24'h0, w}, "");
			ahb(1'b1, `ADDR_PC, {8'h0, pl, pc}, "");
			ahb(1'b1, `ADDR_CTRL, {31'h0, c0}, "");
			run(2'h0, 1'b0, f);
			pc = pc + ((m < w) ? 16'h2 : 16'h1);
			ahb(1'b0, `ADDR_PC, {8'h0, pl, pc}, "pc");
			ahb(1'b0, `ADDR_WORKING_REGISTER, {24'h0, w}, "working_register");
			ahb(1'b0, `ADDR_CTRL, {31'h0, c0}, "ctrl");
			ahb(1'b0, ma(f), {24'h0, m}, "mem");
			ahb(1'b0, `ADDR_STATUS, {30'h0, m < w, 1'b0}, "status");
		end
		$display("compare test done");
		// sums of two packed decimals kept below 100, so no carry out
		for (int i = 0; i < 12; i++) begin
			a = $urandom % 50;
			b = $urandom % 50;
			bn = bcd(a) + bcd(b);
			dc = (bcd(a) & 8'h0F) + (bcd(b) & 8'h0F) > 8'h0F;
			r = bcd(a + b);
			decimal_adjust_accumulator(bn, dc, i[0], 8'($urandom), r);
		end
		decimal_adjust_accumulator(8'hA5, 1'b0, 1'b0, 8'h3C, 8'h05);
		$display("decimal adjust test done");
		// even passes return from interrupt, odd ones with a literal
		for (int i = 0; i < 8; i++) begin
			k = 8'($urandom);
			t = 16'($urandom);
			{pl, pc} = 24'($urandom);
			c0 = 1'($urandom);
			ahb(1'b1, `ADDR_CTRL, {30'h0, 1'b1, c0}, "");
			ahb(1'b1, `ADDR_TOS, {16'h0, t}, "");
			ahb(1'b1, `ADDR_PC, {8'h0, pl, pc}, "");
			ahb(1'b1, `ADDR_WORKING_REGISTER, {24'h0, ~k}, "");
			run(i[0] ? 2'h3 : 2'h2, 1'b0, k);
			ahb(1'b0, `ADDR_PC, {8'h0, pl, t}, "pc");
			ahb(1'b0, `ADDR_CTRL, {30'h0, i[0], c0}, "ctrl");
			ahb(1'b0, `ADDR_WORKING_REGISTER, {24'h0, i[0] ? k : ~k}, "working_register");
		end
		$display("return test done");
		ahb(1'b1, 32'h0000_0080, 32'hFFFF_FFFF, "");
		ahb(1'b0, 32'h0000_0080, 32'h0, "unmapped");
		repeat (2) @(posedge hclk);
		print_verdict;
	end
endmodule : tb_compare_bcd_return_exec
`default_nettype wire
